// *** rtl/led_driver_fault_protection.sv ***
/*
  fault sequencing and gate control for a peak current-mode led driver:
  start delay, overvoltage and thermal shutdown, boost hiccup with retry,
  buck-boost short filtering, dimming and the open-drain fault pin.
  assumes all comparator flags and the oscillator tick are synchronous
  to clk, and that reset_n low means undervoltage lockout.
*/
`timescale 1ns/1ps
module led_driver_fault_protection #(
  parameter int unsigned STARTUP_CLKS = led_prot_pkg::STARTUP_CLKS,
  parameter int unsigned RETRY_CLKS   = led_prot_pkg::RETRY_CLKS,
  parameter int unsigned HICCUP_TICKS = led_prot_pkg::HICCUP_TICKS,
  parameter int unsigned BB_TICKS     = led_prot_pkg::BB_SHORT_TICKS
) (
  // clock and undervoltage reset
  input  wire logic clk,
  input  wire logic reset_n,
  // configuration and oscillator
  input  wire logic buck_boost_mode,
  input  wire logic osc_tick,
  // comparator flags
  input  wire logic overvoltage_sense,
  input  wire logic thermal_trip,
  input  wire logic led_short_boost,
  input  wire logic led_sense_high_low,
  input  wire logic cs_trip,
  // dimming
  input  wire logic pwm_dim_input,
  // gate drives and compensation switch
  output logic      switch_gate_drive,
  output logic      dim_gate_drive,
  output logic      comp_connect,
  // open-drain fault pin
  input  wire logic fault_n_in,
  output logic      fault_n_out,
  output logic      fault_n_oe
);

  ////////////////////////////////////////////////////////////////////////
  // reset release through two flip-flops

  logic rst_meta_r;
  logic rst_sync_r;

  // lockout reaches every flop at once; only its release is retimed,
  // so no flop can leave reset on a partial clock period
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // declarations

  localparam logic [led_prot_pkg::CNT_W-1:0] STARTUP_LAST =
    led_prot_pkg::CNT_W'(STARTUP_CLKS - 1);
  localparam logic [led_prot_pkg::CNT_W-1:0] TICKS_LAST   =
    led_prot_pkg::CNT_W'(led_prot_pkg::STARTUP_TICKS - 1);
  localparam logic [led_prot_pkg::CNT_W-1:0] HICCUP_LAST  =
    led_prot_pkg::CNT_W'(HICCUP_TICKS - 1);
  localparam logic [led_prot_pkg::CNT_W-1:0] RETRY_LAST   =
    led_prot_pkg::CNT_W'(RETRY_CLKS - 1);
  localparam logic [led_prot_pkg::QUAL_W-1:0] QUAL_FULL   =
    led_prot_pkg::QUAL_W'(led_prot_pkg::SHORT_QUAL_CLKS);

  led_prot_pkg::seq_state_t             state_r;
  led_prot_pkg::seq_state_t             state_nxt;
  logic [led_prot_pkg::CNT_W-1:0]       cnt_r;
  logic [led_prot_pkg::CNT_W-1:0]       cnt_nxt;
  logic [led_prot_pkg::QUAL_W-1:0]      qual_r;
  logic [led_prot_pkg::QUAL_W-1:0]      qual_nxt;
  logic                                 short_qual;
  logic                                 running;
  logic                                 in_hiccup;
  logic                                 in_retry;
  logic                                 shutdown;
  logic                                 sw_enable;
  logic                                 pulse_on;
  logic                                 bb_fault;
  logic                                 any_fault;
  logic                                 sw_gate_r;
  logic                                 sw_gate_nxt;
  logic                                 dim_gate_r;
  logic                                 dim_gate_nxt;
  logic                                 comp_conn_r;
  logic                                 comp_conn_nxt;
  logic                                 flt_oe_r;
  logic                                 flt_oe_nxt;
  logic                                 flt_out_r;

  ////////////////////////////////////////////////////////////////////////
  // boost short qualification

  // saturates at full scale; held clear in hiccup so that every retry
  // needs a fresh, full-length short before it can trip again
  // short must persist before hiccup
  always_comb begin
    qual_nxt = '0;
    if (!buck_boost_mode && led_short_boost && state_r != led_prot_pkg::ST_HICCUP) begin
      if (qual_r != QUAL_FULL) begin
        qual_nxt = qual_r + 1'b1;
      end else begin
        qual_nxt = qual_r;
      end
    end
  end

  assign short_qual = (qual_r == QUAL_FULL);

  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      qual_r <= '0;
    end else begin
      qual_r <= qual_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // start-up and hiccup sequencing

  // one counter serves every timed state; it is cleared on each move
  // so that a state always starts its count from zero
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    unique case (state_r)
      led_prot_pkg::ST_DELAY: begin
        if (cnt_r == STARTUP_LAST) begin
          state_nxt = led_prot_pkg::ST_PRESTART;
          cnt_nxt   = '0;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      led_prot_pkg::ST_PRESTART: begin
        if (osc_tick) begin
          if (cnt_r == TICKS_LAST) begin
            state_nxt = led_prot_pkg::ST_RUN;
            cnt_nxt   = '0;
          end else begin
            cnt_nxt = cnt_r + 1'b1;
          end
        end
      end
      led_prot_pkg::ST_RUN: begin
        if (short_qual) begin
          state_nxt = led_prot_pkg::ST_HICCUP;
          cnt_nxt   = '0;
        end
      end
      led_prot_pkg::ST_HICCUP: begin
        if (osc_tick) begin
          if (cnt_r == HICCUP_LAST) begin
            state_nxt = led_prot_pkg::ST_RETRY;
            cnt_nxt   = '0;
          end else begin
            cnt_nxt = cnt_r + 1'b1;
          end
        end
      end
      led_prot_pkg::ST_RETRY: begin
        if (short_qual) begin
          state_nxt = led_prot_pkg::ST_HICCUP;
          cnt_nxt   = '0;
        end else if (cnt_r == RETRY_LAST) begin
          state_nxt = led_prot_pkg::ST_RUN;
          cnt_nxt   = '0;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      default: begin
        state_nxt = led_prot_pkg::ST_DELAY;
        cnt_nxt   = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      state_r <= led_prot_pkg::ST_DELAY;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // fault and enable decode

  assign in_hiccup = (state_r == led_prot_pkg::ST_HICCUP);
  assign in_retry  = (state_r == led_prot_pkg::ST_RETRY);
  assign running   = (state_r == led_prot_pkg::ST_RUN) || in_retry;

  // not yet running counts as shutdown, which keeps the switch gate off and the dim gate
  // high through the start delay and the hiccup interval
  // shutdown faults win over dimming
  assign shutdown  = overvoltage_sense || thermal_trip || in_hiccup || !running;
  // buck-boost short does not gate switching
  assign sw_enable = !shutdown && pwm_dim_input;

  // any listed fault pulls the pin
  assign any_fault = overvoltage_sense || thermal_trip || in_hiccup || in_retry || bb_fault;

  ////////////////////////////////////////////////////////////////////////
  // on-pulse generation with blanking

  on_pulse_ctrl u_on_pulse (
    .clk      (clk),
    .rst_n    (rst_sync_r),
    .enable   (sw_enable),
    .osc_tick (osc_tick),
    .cs_trip  (cs_trip),
    .gate_on  (pulse_on)
  );

  ////////////////////////////////////////////////////////////////////////
  // buck-boost short filter

  // the filter runs only once switching has started, so a short seen
  // during the start delay leaves no stale count behind
  bb_short_counter #(
    .LIMIT (BB_TICKS)
  ) u_bb_short (
    .clk         (clk),
    .rst_n       (rst_sync_r),
    .active      (buck_boost_mode && running),
    .osc_tick    (osc_tick),
    .short_ind   (led_sense_high_low),
    .short_fault (bb_fault)
  );

  ////////////////////////////////////////////////////////////////////////
  // output drive values

  // the gate term repeats the enable so that a fault cuts a pulse one
  // cycle sooner than waiting for the pulse logic to drop it
  always_comb begin
    sw_gate_nxt   = pulse_on && sw_enable;
    // dim gate low only when enabled
    dim_gate_nxt  = !sw_enable;
    // comp open in hiccup or dim low
    comp_conn_nxt = pwm_dim_input && !in_hiccup && running;
    flt_oe_nxt    = any_fault;
  end

  // switch gate off, dim gate high and fault released at lockout
  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      sw_gate_r   <= led_prot_pkg::RST_SW_GATE;
      dim_gate_r  <= led_prot_pkg::RST_DIM_GATE;
      comp_conn_r <= led_prot_pkg::RST_COMP_CONN;
      flt_oe_r    <= 1'b0;
      flt_out_r   <= 1'b0;
    end else begin
      sw_gate_r   <= sw_gate_nxt;
      dim_gate_r  <= dim_gate_nxt;
      comp_conn_r <= comp_conn_nxt;
      flt_oe_r    <= flt_oe_nxt;
      flt_out_r   <= 1'b0;  // open drain only ever pulls low
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ports

  assign switch_gate_drive = sw_gate_r;
  assign dim_gate_drive    = dim_gate_r;
  assign comp_connect      = comp_conn_r;
  // pin readback is not needed: the fault state is the enable itself
  // open-drain pin driven low when enabled
  assign fault_n_out       = flt_out_r;
  assign fault_n_oe        = flt_oe_r;

endmodule

// *** rtl/led_prot_pkg.sv ***
/*
  constants, timing figures and state encodings for the led driver
  protection block.
  assumes a 250 mhz system clock and an oscillator tick that marks the
  start of each switching cycle.
*/
package led_prot_pkg;

  ////////////////////////////////////////////////////////////////////////
  // clock and derived timing
  localparam int unsigned CLK_PERIOD_NS   = 4;
  // leading-edge blanking, least time, rounded up
  localparam int unsigned BLANK_NS        = 50;
  localparam int unsigned BLANK_CLKS      = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // boost short must persist this long before hiccup, rounded up
  localparam int unsigned SHORT_QUAL_NS   = 1000;
  localparam int unsigned SHORT_QUAL_CLKS =
    (SHORT_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // retry window after hiccup
  localparam int unsigned RETRY_US        = 20;
  localparam int unsigned RETRY_CLKS      = RETRY_US * 1000 / CLK_PERIOD_NS;
  // fixed part of the power-up start delay
  localparam int unsigned STARTUP_US      = 300;
  localparam int unsigned STARTUP_CLKS    = STARTUP_US * 1000 / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////
  // counts in switching cycles
  localparam int unsigned STARTUP_TICKS   = 64;
  localparam int unsigned HICCUP_TICKS    = 8192;
  localparam int unsigned BB_SHORT_TICKS  = 8192;

  ////////////////////////////////////////////////////////////////////////
  // widths and reset values
  localparam int unsigned CNT_W           = 20;
  localparam int unsigned BB_CNT_W        = 14;
  localparam int unsigned BLANK_W         = 4;
  localparam int unsigned QUAL_W          = 8;
  localparam logic        RST_SW_GATE     = 1'b0;
  localparam logic        RST_DIM_GATE    = 1'b1;
  localparam logic        RST_COMP_CONN   = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // sequencing states, gray along the usual path
  typedef enum logic [2:0] {
    ST_DELAY    = 3'h0,
    ST_PRESTART = 3'h1,
    ST_RUN      = 3'h3,
    ST_HICCUP   = 3'h2,
    ST_RETRY    = 3'h6
  } seq_state_t;

endpackage

// *** rtl/on_pulse_ctrl.sv ***
/*
  on-pulse timing for peak current-mode control with leading-edge
  blanking of the switch current comparator.
  assumes osc_tick is a one-cycle pulse per switching cycle and cs_trip
  is synchronous to clk.
*/
`timescale 1ns/1ps
module on_pulse_ctrl (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control
  input  wire logic enable,
  input  wire logic osc_tick,
  input  wire logic cs_trip,
  // pulse
  output logic      gate_on
);

  logic                              on_r;
  logic                              on_nxt;
  logic [led_prot_pkg::BLANK_W-1:0]  blank_r;
  logic [led_prot_pkg::BLANK_W-1:0]  blank_nxt;

  ////////////////////////////////////////////////////////////////////////
  // start, blank and end each on-pulse
  always_comb begin
    on_nxt    = on_r;
    blank_nxt = blank_r;
    if (!enable) begin
      on_nxt    = 1'b0;
      blank_nxt = '0;
    end else if (osc_tick) begin
      on_nxt    = 1'b1;
      blank_nxt = led_prot_pkg::BLANK_W'(led_prot_pkg::BLANK_CLKS);
    end else if (on_r) begin
      if (blank_r != '0) begin
        blank_nxt = blank_r - 1'b1;
      end else if (cs_trip) begin
        on_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      on_r    <= 1'b0;
      blank_r <= '0;
    end else begin
      on_r    <= on_nxt;
      blank_r <= blank_nxt;
    end
  end

  assign gate_on = on_r;

endmodule

// *** rtl/bb_short_counter.sv ***
/*
  saturating up/down counter that filters the buck-boost string short
  indication per switching cycle.
  assumes short_ind and osc_tick are synchronous to clk.
*/
`timescale 1ns/1ps
module bb_short_counter #(
  parameter int unsigned LIMIT = led_prot_pkg::BB_SHORT_TICKS
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // inputs
  input  wire logic active,
  input  wire logic osc_tick,
  input  wire logic short_ind,
  // filtered fault
  output logic      short_fault
);

  logic [led_prot_pkg::BB_CNT_W-1:0] cnt_r;
  logic [led_prot_pkg::BB_CNT_W-1:0] cnt_nxt;
  logic                              flt_r;
  logic                              flt_nxt;

  ////////////////////////////////////////////////////////////////////////
  // count up on short cycles, down on clean ones
  always_comb begin
    cnt_nxt = cnt_r;
    flt_nxt = flt_r;
    if (!active) begin
      cnt_nxt = '0;
      flt_nxt = 1'b0;
    end else if (osc_tick) begin
      // up count, fault at full scale
      if (short_ind) begin
        if (cnt_r != led_prot_pkg::BB_CNT_W'(LIMIT - 1)) begin
          cnt_nxt = cnt_r + 1'b1;
        end else begin
          flt_nxt = 1'b1;
        end
      end else begin
        if (cnt_r != '0) begin
          cnt_nxt = cnt_r - 1'b1;
        end else begin
          flt_nxt = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      flt_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      flt_r <= flt_nxt;
    end
  end

  assign short_fault = flt_r;

endmodule

// *** testbench/led_prot_checker.sv ***
/*
  port checker for the led driver protection block.
  assumes it is bound to the top module and sees a free-running clk.
*/
`timescale 1ns/1ps
module led_prot_checker #(
  parameter int unsigned RETRY_CLKS = 30
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // inputs
  input wire logic buck_boost_mode,
  input wire logic osc_tick,
  input wire logic overvoltage_sense,
  input wire logic thermal_trip,
  input wire logic led_short_boost,
  input wire logic cs_trip,
  input wire logic pwm_dim_input,
  // outputs
  input wire logic switch_gate_drive,
  input wire logic dim_gate_drive,
  input wire logic comp_connect,
  input wire logic fault_n_oe
);
  logic [1:0]  up_r;
  logic [7:0]  on_r;
  logic [7:0]  qual_r;
  logic [15:0] ret_r;
  logic        ran_r;
  logic        live;
  logic        q;

  // settled after the reset synchroniser, and no shutdown request
  assign live = (up_r == 2'h3);
  assign q    = pwm_dim_input && !overvoltage_sense && !thermal_trip;

  ////////////////////////////////////////////////////////////////////////
  // history counters
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      up_r   <= 2'h0;
      on_r   <= 8'h00;
      qual_r <= 8'h00;
      ret_r  <= 16'h0000;
      ran_r  <= 1'b0;
    end else begin
      up_r   <= live ? up_r : up_r + 2'h1;
      on_r   <= !switch_gate_drive ? 8'h00 : (on_r == 8'hff ? on_r : on_r + 8'h01);
      qual_r <= !(led_short_boost && !buck_boost_mode) ? 8'h00 :
                (qual_r == 8'hff ? qual_r : qual_r + 8'h01);
      ret_r  <= !(fault_n_oe && comp_connect) ? 16'h0000 : ret_r + 16'h0001;
      ran_r  <= ran_r || switch_gate_drive;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // properties
  chk_ovp_shutdown: assert property (@(posedge clk) disable iff (!reset_n)
    live && overvoltage_sense |=> !switch_gate_drive && dim_gate_drive && fault_n_oe)
    else $error("overvoltage did not shut down");
  chk_hot_shutdown: assert property (@(posedge clk) disable iff (!reset_n)
    live && thermal_trip |=> !switch_gate_drive && dim_gate_drive && fault_n_oe)
    else $error("overtemperature did not shut down");
  chk_dim_low_opens: assert property (@(posedge clk) disable iff (!reset_n)
    live && !pwm_dim_input |=> !comp_connect && dim_gate_drive)
    else $error("dimming low left comp or dim gate wrong");
  chk_blank_ignore: assert property (@(posedge clk) disable iff (!reset_n)
    live && q && $rose(cs_trip) && switch_gate_drive && on_r < 8'd8 |=> switch_gate_drive[*4])
    else $error("early current trip ended the pulse");
  chk_trip_ends: assert property (@(posedge clk) disable iff (!reset_n)
    live && cs_trip && switch_gate_drive && on_r > 8'd15 |-> ##[1:3] !switch_gate_drive)
    else $error("current trip did not end the pulse");
  chk_short_hiccup: assert property (@(posedge clk) disable iff (!reset_n)
    live && ran_r && qual_r == 8'd250 |->
      ##[1:4] (!switch_gate_drive && dim_gate_drive && !comp_connect && fault_n_oe))
    else $error("boost short did not start hiccup");
  chk_retry_latched: assert property (@(posedge clk) disable iff (!reset_n)
    live && fault_n_oe && ret_r != 16'h0000 && ret_r < 16'(RETRY_CLKS - 2) && q &&
      !buck_boost_mode && !$past(overvoltage_sense) && !$past(thermal_trip) |=> fault_n_oe)
    else $error("fault released early in retry");
  chk_bb_switching: assert property (@(posedge clk) disable iff (!reset_n)
    live && ran_r && buck_boost_mode && osc_tick && q ##1 q |-> ##1 switch_gate_drive)
    else $error("buck-boost switching stopped");
  chk_lockout_idle: assert property (@(posedge clk)
    !reset_n |-> !switch_gate_drive && dim_gate_drive && !comp_connect && !fault_n_oe)
    else $error("lockout left outputs active");
endmodule

bind led_driver_fault_protection led_prot_checker #(
  .RETRY_CLKS(RETRY_CLKS)
) prot_chk (
  .clk              (clk),
  .reset_n          (reset_n),
  .buck_boost_mode  (buck_boost_mode),
  .osc_tick         (osc_tick),
  .overvoltage_sense(overvoltage_sense),
  .thermal_trip     (thermal_trip),
  .led_short_boost  (led_short_boost),
  .cs_trip          (cs_trip),
  .pwm_dim_input    (pwm_dim_input),
  .switch_gate_drive(switch_gate_drive),
  .dim_gate_drive   (dim_gate_drive),
  .comp_connect     (comp_connect),
  .fault_n_oe       (fault_n_oe)
);

// *** testbench/led_string_model.sv ***
/*
  far-side model: switch current ramp with its comparator, and the
  pulled-up fault line.
  assumes the bench sets the trip delay in clock cycles.
*/
`timescale 1ns/1ps
module led_string_model (
  // clock
  input  wire logic       clk,
  // from the block
  input  wire logic       switch_gate_drive,
  input  wire logic       fault_n_out,
  input  wire logic       fault_n_oe,
  // bench control
  input  wire logic [7:0] trip_delay,
  // to the block
  output logic            cs_trip,
  output logic            fault_pin
);
  logic [7:0] ramp_r = 8'h00;

  // current ramps while the switch conducts, comparator trips at the delay
  always @(negedge clk) begin
    if (switch_gate_drive) begin
      ramp_r  <= ramp_r + 8'h01;
      cs_trip <= (ramp_r + 8'h01 >= trip_delay);
    end else begin
      ramp_r  <= 8'h00;
      cs_trip <= 1'b0;
    end
  end

  assign fault_pin = fault_n_oe ? fault_n_out : 1'b1;
endmodule

// *** testbench/tb_led_driver_fault_protection.sv ***
/*
  self-checking bench for the led driver protection block.
  assumes the design, checker and string model are compiled first.
*/
`timescale 1ns/1ps
module tb_led_driver_fault_protection;
  localparam int unsigned RT = 300;
  localparam int unsigned HT = 4;
  localparam int unsigned BT = 4;
  logic       clk, reset_n, buck_boost_mode, osc_tick, overvoltage_sense;
  logic       thermal_trip, led_short_boost, led_sense_high_low, pwm_dim_input;
  logic       cs_trip, switch_gate_drive, dim_gate_drive, comp_connect;
  logic       fault_n_out, fault_n_oe, fault_pin;
  logic [7:0] trip_delay;
  int         fails = 0, checked = 0, tick_n = 0, rises = 0;

  led_driver_fault_protection #(
    .STARTUP_CLKS(20), .RETRY_CLKS(RT), .HICCUP_TICKS(HT), .BB_TICKS(BT)
  ) DUT (
    .clk(clk), .reset_n(reset_n), .buck_boost_mode(buck_boost_mode),
    .osc_tick(osc_tick), .overvoltage_sense(overvoltage_sense),
    .thermal_trip(thermal_trip), .led_short_boost(led_short_boost),
    .led_sense_high_low(led_sense_high_low), .cs_trip(cs_trip),
    .pwm_dim_input(pwm_dim_input), .switch_gate_drive(switch_gate_drive),
    .dim_gate_drive(dim_gate_drive), .comp_connect(comp_connect),
    .fault_n_in(fault_pin), .fault_n_out(fault_n_out), .fault_n_oe(fault_n_oe)
  );

  led_string_model far_side (
    .clk(clk), .switch_gate_drive(switch_gate_drive), .fault_n_out(fault_n_out),
    .fault_n_oe(fault_n_oe), .trip_delay(trip_delay), .cs_trip(cs_trip),
    .fault_pin(fault_pin)
  );

  ////////////////////////////////////////////////////////////////////////
  // clock, oscillator tick every 32 cycles, event counters
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    osc_tick = 1'b0;
    forever begin
      repeat (31) @(negedge clk);
      osc_tick = 1'b1;
      @(negedge clk);
      osc_tick = 1'b0;
    end
  end
  always @(posedge clk) if (osc_tick) tick_n <= tick_n + 1;
  always @(posedge switch_gate_drive) rises <= rises + 1;

  ////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic ticks(input int n);
    int t;
    t = tick_n + n;
    while (tick_n != t) @(negedge clk);
  endtask
  task automatic idle_pt;
    @(negedge clk);
    while (switch_gate_drive) @(negedge clk);
  endtask
  task automatic gate_len(output int n);
    n = 0;
    while (!switch_gate_drive) @(negedge clk);
    while (switch_gate_drive) begin
      n++;
      @(negedge clk);
    end
  endtask
  task automatic summarize;
    if (fails == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_start(input logic bb);
    int n;
    reset_n = 1'b0;
    buck_boost_mode = bb;
    cyc(8);
    check({switch_gate_drive, dim_gate_drive, comp_connect, fault_pin}, 4'b0101);
    reset_n = 1'b1;
    n = tick_n;
    while (!switch_gate_drive) @(negedge clk);
    check(tick_n - n >= 65 && tick_n - n <= 67, 1'b1);
  endtask
  task automatic t_pulse;
    int n;
    idle_pt;
    gate_len(n);
    check(n >= 13 && n <= 16, 1'b1);
    trip_delay = 8'h14;
    idle_pt;
    gate_len(n);
    check(n >= 20 && n <= 23, 1'b1);
    trip_delay = 8'h04;
  endtask
  task automatic t_dim;
    int r;
    idle_pt;
    pwm_dim_input = 1'b0;
    cyc(2);
    r = rises;
    check({switch_gate_drive, dim_gate_drive, comp_connect}, 3'b010);
    ticks(2);
    check(rises, r);
    pwm_dim_input = 1'b1;
    cyc(2);
    check({dim_gate_drive, comp_connect}, 2'b01);
    ticks(2);
    check(rises > r, 1'b1);
  endtask
  task automatic t_shut;
    int r;
    for (int i = 0; i < 2; i++) begin
      idle_pt;
      r = rises;
      {thermal_trip, overvoltage_sense} = (i == 0) ? 2'b01 : 2'b10;
      cyc(2);
      check({switch_gate_drive, dim_gate_drive, fault_pin}, 3'b010);
      ticks(3);
      check(rises, r);
      {thermal_trip, overvoltage_sense} = 2'b00;
      cyc(2);
      check({dim_gate_drive, fault_pin}, 2'b01);
      ticks(2);
      check(rises > r, 1'b1);
    end
  endtask
  task automatic t_hiccup;
    int t, n;
    idle_pt;
    led_short_boost = 1'b1;
    cyc(255);
    check({switch_gate_drive, dim_gate_drive, comp_connect, fault_pin}, 4'b0100);
    t = tick_n;
    while (!comp_connect) @(negedge clk);
    check(tick_n - t >= HT - 1 && tick_n - t <= HT + 1, 1'b1);
    check(fault_pin, 1'b0);
    cyc(130);
    check(fault_pin, 1'b0);
    cyc(130);
    check({comp_connect, fault_pin}, 2'b00);
    led_short_boost = 1'b0;
    while (!comp_connect) @(negedge clk);
    n = 0;
    while (!fault_pin) begin
      n++;
      @(negedge clk);
    end
    check(n >= RT - 1 && n <= RT + 2, 1'b1);
  endtask
  task automatic t_bb;
    int n, r;
    t_start(1'b1);
    ticks(1);
    led_sense_high_low = 1'b1;
    ticks(BT - 1);
    led_sense_high_low = 1'b0;
    cyc(3);
    check(fault_pin, 1'b1);
    ticks(BT);
    for (int s = 1; s >= 0; s--) begin
      led_sense_high_low = s[0];
      n = 0;
      while (fault_pin === s[0] && n < 3 * BT) begin
        ticks(1);
        cyc(3);
        n++;
      end
      check(n, BT);
      r = rises;
      ticks(2);
      check(rises > r, 1'b1);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    reset_n = 1'b1;
    buck_boost_mode = 1'b0;
    overvoltage_sense = 1'b0;
    thermal_trip = 1'b0;
    led_short_boost = 1'b0;
    led_sense_high_low = 1'b0;
    pwm_dim_input = 1'b1;
    trip_delay = 8'h04;
    cyc(1);
    t_start(1'b0);
    t_pulse;
    t_dim;
    t_shut;
    t_hiccup;
    t_bb;
    summarize;
  end
  initial begin
    #200000;
    fails++;
    summarize;
  end
endmodule
